/* File: core/eam_energy_acc.sv */
`timescale 1ns/1ps
module eam_energy_acc #(
    parameter int SAMPLE_CYCLES = eam_pkg::SAMPLE_CYC,
    parameter int PW            = 28
) (
    // Clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       sys_rst_i,
    // Configuration
    input  wire logic [eam_pkg::REG_W-1:0]  accumulation_mode_reg_i,
    input  wire logic [eam_pkg::REG_W-1:0]  line_cycle_mode_reg_i,
    input  wire logic [eam_pkg::CNT_W-1:0]  half_cycle_count_target_i,
    input  wire logic                       target_write_i,
    input  wire logic [47:0]                energy_pulse_threshold_i,
    input  wire logic [eam_pkg::STAT_W-1:0] irq_mask_reg_0_i,
    input  wire logic [eam_pkg::STAT_W-1:0] status_clear_i,
    input  wire logic                       status_write_i,
    // Instantaneous samples: index 0 A, 1 B, 2 C
    input  wire logic signed [PW-1:0]       volt_i [3],
    input  wire logic signed [PW-1:0]       curr_i [3],
    input  wire logic signed [PW-1:0]       fund_power_i [3],
    input  wire logic signed [PW-1:0]       rms_ac_line_i,
    input  wire logic signed [PW-1:0]       rms_b_phase_i,
    input  wire logic [2:0]                 zero_cross_i,
    // Accumulator read strobes, one per accumulator
    input  wire logic [5:0]                 acc_read_i,
    // Results
    output logic [eam_pkg::ACC_W-1:0]       phase_total_energy_acc_o [3],
    output logic [eam_pkg::ACC_W-1:0]       phase_fund_energy_acc_o [3],
    output logic signed [PW-1:0]            phase_b_voltage_rms_o,
    output logic [2:0]                      pulse_request_o,
    output logic [2:0]                      pulse_negative_o,
    output logic                            line_cycle_done_flag_o,
    output logic                            interrupt_out_n_o
);
    localparam int TW = 48;
    localparam logic [1:0] PSIGN_SIGNED = 2'h0; // Every other code gives absolute pulses

    logic [1:0] wiring_select;
    logic [1:0] pulse_sign_mode;
    logic       line_cycle_active_enable;
    logic       clear_on_read_enable;
    logic [2:0] zero_cross_phase_select;
    logic [$clog2(SAMPLE_CYCLES+1)-1:0] tick_cnt_r;
    logic       tick;
    logic signed [PW-1:0] volt_b_eff;
    logic signed [2*PW-1:0] p_tot [3];
    logic signed [TW-1:0] stage_tot_r [3];
    logic signed [TW-1:0] stage_fund_r [3];
    logic [eam_pkg::ACC_W-1:0] run_tot_r [3];
    logic [eam_pkg::ACC_W-1:0] run_fund_r [3];
    logic [eam_pkg::CNT_W-1:0] zx_cnt_r;
    logic       zx_hit;
    logic       interval_end;

    assign wiring_select            = accumulation_mode_reg_i[eam_pkg::WSEL_MSB:eam_pkg::WSEL_LSB];
    assign pulse_sign_mode          = accumulation_mode_reg_i[eam_pkg::PSIGN_MSB:eam_pkg::PSIGN_LSB];
    assign line_cycle_active_enable = line_cycle_mode_reg_i[eam_pkg::LC_EN_BIT];
    assign clear_on_read_enable     = line_cycle_mode_reg_i[eam_pkg::CLR_RD_BIT];
    assign zero_cross_phase_select  = line_cycle_mode_reg_i[eam_pkg::ZX_C_BIT:eam_pkg::ZX_A_BIT];

    // Sample tick, one per power sample interval
    assign tick = (tick_cnt_r == ($bits(tick_cnt_r))'(SAMPLE_CYCLES - 1));
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    always_comb begin
        unique case (wiring_select)
            eam_pkg::WSEL_MEAS:  volt_b_eff = volt_i[1];
            eam_pkg::WSEL_3W:    volt_b_eff = volt_i[0] - volt_i[2];
            eam_pkg::WSEL_NEGAC: volt_b_eff = -volt_i[0] - volt_i[2];
            eam_pkg::WSEL_NEGA:  volt_b_eff = -volt_i[0];
        endcase
    end
    assign p_tot[0] = volt_i[0] * curr_i[0];
    assign p_tot[1] = volt_b_eff * curr_i[1];
    assign p_tot[2] = volt_i[2] * curr_i[2];

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            phase_b_voltage_rms_o <= '0;
        end else begin
            phase_b_voltage_rms_o <= (wiring_select == eam_pkg::WSEL_3W) ? rms_ac_line_i : rms_b_phase_i;
        end
    end

    assign zx_hit       = |(zero_cross_i & zero_cross_phase_select);
    assign interval_end = zx_hit && ((zx_cnt_r + 1'b1) >= half_cycle_count_target_i);
    // counter runs regardless of mode; target write restarts it in line mode only
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            zx_cnt_r <= eam_pkg::CNT_RST;
        end else if (target_write_i && line_cycle_active_enable) begin
            zx_cnt_r <= eam_pkg::CNT_RST;
        end else if (interval_end) begin
            zx_cnt_r <= eam_pkg::CNT_RST;
        end else if (zx_hit) begin
            zx_cnt_r <= zx_cnt_r + 1'b1;
        end
    end

    for (genvar ph = 0; ph < 3; ph++) begin : g_phase
        logic signed [TW-1:0] tot_sum;
        logic signed [TW-1:0] fund_sum;
        logic tot_over;
        logic fund_over;
        logic tot_under;
        logic fund_under;
        logic [eam_pkg::ACC_W-1:0] tot_step;
        logic [eam_pkg::ACC_W-1:0] fund_step;
        logic [eam_pkg::ACC_W-1:0] tot_next;
        logic [eam_pkg::ACC_W-1:0] fund_next;
        logic signed [TW-1:0] thr;
        assign thr        = $signed(energy_pulse_threshold_i);
        assign tot_sum    = stage_tot_r[ph] + TW'(p_tot[ph] >>> PW);
        assign fund_sum   = stage_fund_r[ph] + TW'(fund_power_i[ph]);
        assign tot_over   = tick && (tot_sum >= thr);
        assign tot_under  = tick && (tot_sum <= -thr);
        assign fund_over  = tick && (fund_sum >= thr);
        assign fund_under = tick && (fund_sum <= -thr);
        assign tot_step   = tot_over ? 32'h0000_0001 : (tot_under ? 32'hFFFF_FFFF : 32'h0000_0000);
        assign fund_step  = fund_over ? 32'h0000_0001 : (fund_under ? 32'hFFFF_FFFF : 32'h0000_0000);
        assign tot_next   = run_tot_r[ph] + tot_step;
        assign fund_next  = run_fund_r[ph] + fund_step;

        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                stage_tot_r[ph]  <= '0;
                stage_fund_r[ph] <= '0;
            end else if (tick) begin
                stage_tot_r[ph]  <= tot_over ? tot_sum - thr : (tot_under ? tot_sum + thr : tot_sum);
                stage_fund_r[ph] <= fund_over ? fund_sum - thr : (fund_under ? fund_sum + thr : fund_sum);
            end
        end

        // one path feeds both methods; latch at interval end
        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                run_tot_r[ph]                <= eam_pkg::ACC_RST;
                run_fund_r[ph]               <= eam_pkg::ACC_RST;
                phase_total_energy_acc_o[ph] <= eam_pkg::ACC_RST;
                phase_fund_energy_acc_o[ph]  <= eam_pkg::ACC_RST;
            end else if (line_cycle_active_enable) begin
                // interval sum restarts at each boundary
                if (interval_end) begin
                    phase_total_energy_acc_o[ph] <= tot_next;
                    phase_fund_energy_acc_o[ph]  <= fund_next;
                    run_tot_r[ph]                <= eam_pkg::ACC_RST;
                    run_fund_r[ph]               <= eam_pkg::ACC_RST;
                end else begin
                    run_tot_r[ph]  <= tot_next;
                    run_fund_r[ph] <= fund_next;
                end
            end else begin
                // clear after read, pulse arriving that cycle kept
                run_tot_r[ph]                <= eam_pkg::ACC_RST;
                run_fund_r[ph]               <= eam_pkg::ACC_RST;
                phase_total_energy_acc_o[ph] <= (clear_on_read_enable && acc_read_i[ph])
                                                ? tot_step : phase_total_energy_acc_o[ph] + tot_step;
                phase_fund_energy_acc_o[ph]  <= (clear_on_read_enable && acc_read_i[ph+3])
                                                ? fund_step : phase_fund_energy_acc_o[ph] + fund_step;
            end
        end

        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                pulse_request_o[ph]  <= 1'b0;
                pulse_negative_o[ph] <= 1'b0;
            end else begin
                pulse_request_o[ph]  <= tot_over || tot_under;
                pulse_negative_o[ph] <= tot_under && (pulse_sign_mode == PSIGN_SIGNED);
            end
        end
    end

    // done flag set, write-one clear, set wins
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            line_cycle_done_flag_o <= 1'b0;
        end else if (line_cycle_active_enable && interval_end) begin
            line_cycle_done_flag_o <= 1'b1;
        end else if (status_write_i && status_clear_i[eam_pkg::LC_DONE_BIT]) begin
            line_cycle_done_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            interrupt_out_n_o <= 1'b1;
        end else begin
            interrupt_out_n_o <= ~(line_cycle_done_flag_o & irq_mask_reg_0_i[eam_pkg::LC_DONE_BIT]);
        end
    end

    done_set_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        line_cycle_active_enable && interval_end |=> line_cycle_done_flag_o)
        else $error("done flag not set");
    done_clr_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        status_write_i && status_clear_i[eam_pkg::LC_DONE_BIT] && !interval_end |=> !line_cycle_done_flag_o)
        else $error("done flag not cleared");
    irq_level_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        line_cycle_done_flag_o && irq_mask_reg_0_i[eam_pkg::LC_DONE_BIT] |=> !interrupt_out_n_o)
        else $error("interrupt not asserted");
    target_rst_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        target_write_i && line_cycle_active_enable |=> zx_cnt_r == eam_pkg::CNT_RST)
        else $error("counter not reset by target write");
    zx_step_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        zx_hit && !interval_end && !target_write_i |=> zx_cnt_r == $past(zx_cnt_r) + 1'b1)
        else $error("counter did not advance");
    zx_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !zx_hit && !target_write_i |=> $stable(zx_cnt_r))
        else $error("counter moved without crossing");
    rms_route_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wiring_select == eam_pkg::WSEL_3W |=> phase_b_voltage_rms_o == $past(rms_ac_line_i))
        else $error("phase B rms not line rms");
    lc_latch_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        line_cycle_active_enable && interval_end |=> run_tot_r[0] == eam_pkg::ACC_RST)
        else $error("interval sum not restarted");
    // no done flag rise outside mode
    no_done_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !line_cycle_active_enable && !line_cycle_done_flag_o |=> !line_cycle_done_flag_o)
        else $error("done flag set outside line mode");
    // line mode holds the last interval result
    lc_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        line_cycle_active_enable && !interval_end |=> $stable(phase_total_energy_acc_o[0]))
        else $error("line mode result moved mid interval");
    // done flag is sticky until cleared
    flag_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        line_cycle_done_flag_o && !(status_write_i && status_clear_i[eam_pkg::LC_DONE_BIT])
        |=> line_cycle_done_flag_o)
        else $error("done flag dropped without clear");
    // masked flag keeps the pin high
    irq_masked_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !irq_mask_reg_0_i[eam_pkg::LC_DONE_BIT] |=> interrupt_out_n_o)
        else $error("interrupt asserted while masked");
    // pin returns high once flag is clear
    irq_release_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !line_cycle_done_flag_o |=> interrupt_out_n_o)
        else $error("interrupt held without flag");
    // absolute mode never marks a negative pulse
    abs_sign_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        pulse_sign_mode != PSIGN_SIGNED |=> pulse_negative_o == 3'h0)
        else $error("negative pulse in absolute mode");
    // read with clear zeroes the accumulator
    rd_clear_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !line_cycle_active_enable && clear_on_read_enable && acc_read_i[0] && !tick
        |=> phase_total_energy_acc_o[0] == eam_pkg::ACC_RST)
        else $error("accumulator not cleared on read");
    // measured rms kept outside three-wire mode
    rms_meas_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wiring_select != eam_pkg::WSEL_3W |=> phase_b_voltage_rms_o == $past(rms_b_phase_i))
        else $error("phase B rms not measured rms");

    // Main scenarios reached
    interval_c: cover property (@(posedge clock_i) line_cycle_active_enable && interval_end);
    irq_c:      cover property (@(posedge clock_i) $fell(interrupt_out_n_o));
    pulse_c:    cover property (@(posedge clock_i) pulse_request_o[1]);
    clr_c:      cover property (@(posedge clock_i) clear_on_read_enable && acc_read_i[0]);
    flag_clr_c: cover property (@(posedge clock_i) line_cycle_done_flag_o && status_write_i
        && status_clear_i[eam_pkg::LC_DONE_BIT]);
endmodule // eam_energy_acc

/* File: core/eam_pkg.sv */
package eam_pkg;
    // Accumulation mode register fields
    localparam int WSEL_LSB      = 4;
    localparam int WSEL_MSB      = 5;
    localparam int PSIGN_LSB     = 0;
    localparam int PSIGN_MSB     = 1;
    // Line cycle mode register fields
    localparam int LC_EN_BIT     = 0;
    localparam int ZX_A_BIT      = 3;
    localparam int ZX_C_BIT      = 5;
    localparam int CLR_RD_BIT    = 6;
    // Status and mask bit position of line cycle done
    localparam int LC_DONE_BIT   = 5;
    // Widths
    localparam int ACC_W         = 32;
    localparam int CNT_W         = 16;
    localparam int REG_W         = 8;
    localparam int STAT_W        = 16;
    // Wiring select encodings
    localparam logic [1:0] WSEL_MEAS  = 2'h0;
    localparam logic [1:0] WSEL_3W    = 2'h1;
    localparam logic [1:0] WSEL_NEGAC = 2'h2;
    localparam logic [1:0] WSEL_NEGA  = 2'h3;
    // Sample interval of the power stage
    localparam int SAMPLE_NS     = 125000;
    localparam int CLK_NS        = 25;
    localparam int SAMPLE_CYC    = SAMPLE_NS / CLK_NS;
    // Reset values
    localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
endpackage

/* File: testbench/eam_host_model.sv */
`timescale 1ns/1ps
// Host side: owns every configuration word of the block except the pulse threshold
module eam_host_model (
    // Clock
    input  wire logic   clock_i,
    // Configuration words
    output logic [7:0]  acc_mode_o,
    output logic [7:0]  lc_mode_o,
    output logic [15:0] target_o,
    output logic        target_wr_o,
    output logic [15:0] mask_o,
    output logic [15:0] clear_o,
    output logic        clear_wr_o,
    output logic [5:0]  read_o
);
    logic [2:0] b_term_enable; // Bit 1 of the term select of each pulse output

    // Quiet words at time zero
    initial begin
        {acc_mode_o, lc_mode_o, target_o, target_wr_o, mask_o, clear_o, clear_wr_o, read_o} = '0;
        b_term_enable = 3'h7;
    end
    // clear-on-read held low in line mode
    task automatic set_modes(input logic [7:0] am, input logic [7:0] lm, input logic [15:0] mk);
        @(negedge clock_i);
        acc_mode_o = am;
        lc_mode_o  = lm[0] ? (lm & 8'hbf) : lm;
        mask_o     = mk;
        // phase B kept out of every pulse output in three-wire mode
        b_term_enable = (am[5:4] == 2'h1) ? 3'h0 : 3'h7;
    endtask
    // calibration counts crossings of one phase only
    task automatic calibrate_phase(input int p, input logic [15:0] mk);
        @(negedge clock_i);
        lc_mode_o = 8'h01 | (8'h08 << p);
        mask_o    = mk;
    endtask
    // target rewritten in line mode restarts the count
    task automatic write_target(input logic [15:0] t);
        @(negedge clock_i);
        target_o    = t;
        target_wr_o = 1'b1;
        @(negedge clock_i);
        target_wr_o = 1'b0;
    endtask
    // One written to the done position only, so other flags survive
    task automatic clear_done();
        @(negedge clock_i);
        clear_o    = 16'h0020;
        clear_wr_o = 1'b1;
        @(negedge clock_i);
        clear_wr_o = 1'b0;
    endtask
    // Read strobe on all six accumulators
    task automatic read_all();
        @(negedge clock_i);
        read_o = 6'h3f;
        @(negedge clock_i);
        read_o = 6'h00;
    endtask
endmodule // eam_host_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
// Self-checking bench of the energy accumulation block
module tb;
    localparam int S = 8; // Short sample period keeps rows brief
    typedef struct packed {
        logic [1:0]  wsel;
        logic [1:0]  psign;
        logic [31:0] exp_b;
        logic        three_w;
        logic [2:0]  exp_req;
        logic [2:0]  exp_neg;
    } eam_row_type;
    // Wiring select, sign mode, phase B count after four ticks, line rms in B, pulses and signs at tick four
    localparam eam_row_type ROWS [5] = '{'{2'h0, 2'h0, 32'h0000_0002, 1'b0, 3'h7, 3'h0},
        '{2'h1, 2'h0, 32'h0000_0004, 1'b1, 3'h7, 3'h0}, '{2'h2, 2'h0, 32'h0000_0000, 1'b0, 3'h5, 3'h0},
        '{2'h3, 2'h0, 32'hffff_fffe, 1'b0, 3'h7, 3'h2}, '{2'h3, 2'h1, 32'hffff_fffe, 1'b0, 3'h7, 3'h0}};
    localparam logic signed [27:0] P20    = 28'sh010_0000;
    localparam logic signed [27:0] RMS_AC = 28'sh000_1234;
    localparam logic signed [27:0] RMS_B  = 28'sh000_0567;
    logic                clock_i, sys_rst_i, tgt_wr, clr_wr, flag, irq_n;
    logic [7:0]          am, lm;
    logic [15:0]         tgt, mk, clr;
    logic [5:0]          rd;
    logic [2:0]          zx, preq, pneg;
    logic signed [27:0]  volt [3], curr [3], fpow [3], rms_b;
    logic [31:0]         tot [3], fund [3];
    int                  cyc, num_errors, cmp_count, i;
    // Clock at 40 MHz
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // Cycles since reset release; sample ticks fall near multiples of S
    always_ff @(posedge clock_i) cyc <= sys_rst_i ? 0 : cyc + 1;
    eam_host_model i_eam_host_model (.clock_i(clock_i), .acc_mode_o(am), .lc_mode_o(lm), .target_o(tgt),
        .target_wr_o(tgt_wr), .mask_o(mk), .clear_o(clr), .clear_wr_o(clr_wr), .read_o(rd));
    eam_energy_acc #(.SAMPLE_CYCLES(S)) i_eam_energy_acc (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .accumulation_mode_reg_i(am), .line_cycle_mode_reg_i(lm), .half_cycle_count_target_i(tgt),
        .target_write_i(tgt_wr), .energy_pulse_threshold_i(48'h0000_0000_2000), .irq_mask_reg_0_i(mk),
        .status_clear_i(clr), .status_write_i(clr_wr), .volt_i(volt), .curr_i(curr), .fund_power_i(fpow),
        .rms_ac_line_i(RMS_AC), .rms_b_phase_i(RMS_B), .zero_cross_i(zx), .acc_read_i(rd),
        .phase_total_energy_acc_o(tot), .phase_fund_energy_acc_o(fund), .phase_b_voltage_rms_o(rms_b),
        .pulse_request_o(preq), .pulse_negative_o(pneg), .line_cycle_done_flag_o(flag), .interrupt_out_n_o(irq_n));
    // Verdict and end of run
    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A wait that runs out ends the run as a mismatch
    task automatic give_up();
        num_errors++;
        $display("[ERR] %0t wait ran out", $time);
        complete_run();
    endtask
    task automatic at_cyc(input int c);
        int n;
        for (n = 0; n < 1000 && cyc < c; n++) @(negedge clock_i);
        if (cyc < c) give_up();
    endtask
    task automatic wait_flag(input logic v);
        int n;
        for (n = 0; n < 100 && flag !== v; n++) @(negedge clock_i);
        if (flag !== v) give_up();
    endtask
    // Reset held for two cycles, released on a falling edge
    task automatic restart();
        @(negedge clock_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        sys_rst_i = 1'b0;
    endtask
    // One-cycle zero crossing on one phase
    task automatic zx_pulse(input int p);
        @(negedge clock_i);
        zx[p] = 1'b1;
        @(negedge clock_i);
        zx[p] = 1'b0;
    endtask
    initial begin
        sys_rst_i  = 1'b1;
        zx         = 3'h0;
        volt       = '{P20, P20, -P20};
        curr       = '{P20, P20, -P20};
        fpow       = '{28'sh000_2000, 28'sh000_1000, -28'sh000_2000};
        num_errors = 0;
        cmp_count  = 0;
        // Table rows: fresh reset per row so stage residues never carry over
        for (i = 0; i < 5; i++) begin
            i_eam_host_model.set_modes({2'h0, ROWS[i].wsel, 2'h0, ROWS[i].psign}, 8'h00, 16'h0000);
            restart();
            // Fourth tick lands on this edge, so its one-cycle pulses still stand
            at_cyc(4 * S);
            check(tot[0], 32'h0000_0002);
            check(tot[1], ROWS[i].exp_b);
            check(tot[2], 32'h0000_0002);
            check(fund[2], 32'hffff_fffc);
            check(rms_b, ROWS[i].three_w ? RMS_AC : RMS_B);
            check(preq, ROWS[i].exp_req);
            check(pneg, ROWS[i].exp_neg);
            check(i_eam_host_model.b_term_enable, ROWS[i].three_w ? 3'h0 : 3'h7);
            i_eam_host_model.set_modes({2'h0, ROWS[i].wsel, 2'h0, ROWS[i].psign}, 8'h40, 16'h0000);
            i_eam_host_model.read_all();
            @(negedge clock_i);
            check(tot[0], 32'h0000_0000);
        end
        // Line mode on A and C, crossing on B ignored, interrupt unmasked
        i_eam_host_model.set_modes(8'h00, 8'h29, 16'h0020);
        restart();
        check({flag, irq_n, tot[0][29:0]}, 32'h4000_0000);
        at_cyc(3);
        i_eam_host_model.write_target(16'h0002);
        zx_pulse(0);
        at_cyc(30);
        zx_pulse(1);
        at_cyc(55);
        check(flag, 1'b0);
        check(tot[0], 32'h0000_0000);
        at_cyc(67);
        zx_pulse(2);
        wait_flag(1'b1);
        check(cyc, 69);
        @(negedge clock_i);
        check(irq_n, 1'b0);
        check(tot[0], 32'h0000_0004);
        check(fund[0], 32'h0000_0008);
        check(fund[2], 32'hffff_fff8);
        // Clear by writing one, then a masked interval keeps the pin high
        i_eam_host_model.clear_done();
        wait_flag(1'b0);
        repeat (2) @(negedge clock_i);
        check(irq_n, 1'b1);
        i_eam_host_model.calibrate_phase(0, 16'h0000);
        zx_pulse(0);
        zx_pulse(0);
        wait_flag(1'b1);
        repeat (2) @(negedge clock_i);
        check(irq_n, 1'b1);
        complete_run();
    end
endmodule // tb
